// [shared/flash_pin_regs.svh]
// Constants for the flash pin role and status protection block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FLASH_PIN_REGS_SVH
`define FLASH_PIN_REGS_SVH

// Status bit layout
`define SR_W 6
`define SR_LOCK_POS 5
`define SR_QUAD_POS 4
`define SR_BP_MSB 3
`define SR_BP_LSB 0
`define SR_GUARD_MASK 6'h3f
`define SR_RST 6'h00

// Pin role select and function configuration
`define ROLE_SEL_RST 1'b0
`define FN_W 8
`define FN_RST_DIS_POS 0
`define FN_RST 8'h00

// Link shift geometry
`define BYTE_W 8
`define CNT_W 3
`define CNT_LAST_SINGLE 3'h7
`define CNT_LAST_QUAD 3'h4
`define CNT_STEP_SINGLE 3'h1
`define CNT_STEP_QUAD 3'h4

`endif

// [shared/flash_pin_pkg.sv]
// Types for the flash pin role and status protection block.
// Assumes flash_pin_regs.svh is on the include path.
`include "flash_pin_regs.svh"

package flash_pin_pkg;

  // ----------------------------------------
  // Pin roles and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {ROLE_DATA, ROLE_PAUSE, ROLE_RESET} pin_role_t;

  typedef struct packed {
    logic status_lock_bit;
    logic quad_enable_bit;
    logic [3:0] protect_level;
  } status_t;

  typedef struct packed {
    pin_role_t shared_role;
    logic write_protect_live;
    logic dedicated_reset_live;
  } role_t;

  typedef struct packed {
    logic valid;
    logic [`BYTE_W-1:0] data;
  } byte_t;

endpackage : flash_pin_pkg

// [src/flash_pin_role_and_protect_logic.sv]
// Pin role selection, status write guard, pause and reset handling of a serial flash.
// Assumes the SPI host drives sck, cs_n, data and the pause pin in step; others asynchronous.
`timescale 1ns/1ns
`include "flash_pin_regs.svh"

// ----------------------------------------
// ----------------------------------------

module flash_pin_role_and_protect_logic
  #(
    parameter bit HAS_DEDICATED_RESET = 1'b1
  )
  (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Link clock and frame
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so_o,
    output logic so_oe,
    // Shared write protect / data line two pin
    input wire logic data_line_two_i,
    output logic data_line_two_o,
    output logic data_line_two_oe,
    // Shared pause / reset / data line three pin
    input wire logic data_line_three_i,
    output logic data_line_three_o,
    output logic data_line_three_oe,
    // Dedicated reset pin
    input wire logic reset_pin_n,
    // Status, role select and function configuration writes
    input wire logic status_wr,
    input wire flash_pin_pkg::status_t status_wdata,
    input wire logic role_wr,
    input wire logic role_wdata,
    input wire logic func_wr,
    input wire logic [`FN_W-1:0] func_wdata,
    // Reply data for the link
    input wire logic reply_en,
    input wire logic [`BYTE_W-1:0] tx_byte,
    // Control and status view
    output flash_pin_pkg::status_t status_q,
    output logic pin_role_select_bit,
    output logic [`FN_W-1:0] func_cfg_q,
    output flash_pin_pkg::role_t role_q,
    output logic status_wr_refused,
    output logic pause_active,
    output logic device_in_reset,
    output flash_pin_pkg::byte_t rx_q
  );
  import flash_pin_pkg::*;

  // ----------------------------------------
  // State of the system domain
  // ----------------------------------------
  typedef struct packed {
    logic wp_m;
    logic wp_s;
    logic dl3_m;
    logic dl3_s;
    logic rpin_m;
    logic rpin_s;
    logic cs_m;
    logic cs_s;
    logic drv_m;
    logic drv_s;
    logic rxt_m;
    logic rxt_s;
    logic rxt_seen;
    status_t sr;
    logic role_sel;
    logic [`FN_W-1:0] fn;
    role_t role;
    logic refused;
    logic pause;
    logic pause_role;
    logic dev_rst;
    logic link_rst;
    logic so_oe;
    logic [`BYTE_W-1:0] tx_hold;
    byte_t rx;
  } sys_state_t;

  // ----------------------------------------
  // State of the link domain
  // ----------------------------------------
  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic pause_m;
    logic pause_s;
    logic quad_m;
    logic quad_s;
    logic rep_m;
    logic rep_s;
    logic [`BYTE_W-1:0] sh;
    logic [`CNT_W-1:0] cnt;
    logic [`BYTE_W-1:0] rx_word;
    logic rxt;
    logic [`BYTE_W-1:0] tx;
    logic drv;
    logic so;
  } link_state_t;

  sys_state_t s_q;
  sys_state_t s_d;
  link_state_t l_q;
  link_state_t l_d;
  role_t role_now;
  logic guard_on;
  logic rst_from_shared;
  logic rst_from_pin;

  // ----------------------------------------
  // Role decode
  // ----------------------------------------
  always_comb
  begin
    role_now.write_protect_live = !s_q.sr.quad_enable_bit;
    role_now.dedicated_reset_live = HAS_DEDICATED_RESET && !s_q.fn[`FN_RST_DIS_POS];
    if (s_q.sr.quad_enable_bit)
    begin
      role_now.shared_role = ROLE_DATA;
    end
    else if (role_now.dedicated_reset_live)
    begin
      role_now.shared_role = ROLE_PAUSE;
    end
    else if (s_q.role_sel)
    begin
      role_now.shared_role = ROLE_RESET;
    end
    else
    begin
      role_now.shared_role = ROLE_PAUSE;
    end
  end

  // Protection and reset sources from synchronised pin levels
  assign guard_on = s_q.sr.status_lock_bit && role_now.write_protect_live && !s_q.wp_s;
  assign rst_from_shared = (role_now.shared_role == ROLE_RESET) && !s_q.dl3_s;
  assign rst_from_pin = role_now.dedicated_reset_live && !s_q.rpin_s;

  // ----------------------------------------
  // System domain next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.wp_m = data_line_two_i;
    s_d.wp_s = s_q.wp_m;
    s_d.dl3_m = data_line_three_i;
    s_d.dl3_s = s_q.dl3_m;
    s_d.rpin_m = reset_pin_n;
    s_d.rpin_s = s_q.rpin_m;
    s_d.cs_m = cs_n;
    s_d.cs_s = s_q.cs_m;
    s_d.drv_m = l_q.drv;
    s_d.drv_s = s_q.drv_m;
    s_d.rxt_m = l_q.rxt;
    s_d.rxt_s = s_q.rxt_m;
    s_d.refused = 1'b0;
    s_d.rx.valid = 1'b0;
    s_d.role = role_now;
    if (status_wr)
    begin
      if (guard_on)
      begin
        s_d.refused = 1'b1;
      end
      else
      begin
        s_d.sr = status_wdata;
      end
    end
    if (role_wr)
    begin
      s_d.role_sel = role_wdata;
    end
    if (func_wr)
    begin
      s_d.fn = func_wdata;
    end
    s_d.dev_rst = rst_from_shared || rst_from_pin;
    s_d.link_rst = srst || s_d.dev_rst;
    s_d.pause = (role_now.shared_role == ROLE_PAUSE) && !s_q.dl3_s;
    s_d.pause_role = (role_now.shared_role == ROLE_PAUSE);
    // Output drives only while selected, unpaused and out of reset
    s_d.so_oe = !s_q.cs_s && s_q.drv_s && !s_d.pause && !s_d.dev_rst;
    if (s_q.link_rst)
    begin
      // Link reset rewinds its toggle; follow it without a false byte
      s_d.rxt_seen = s_q.rxt_s;
    end
    else if (s_q.rxt_s != s_q.rxt_seen)
    begin
      s_d.rxt_seen = s_q.rxt_s;
      s_d.rx.valid = 1'b1;
      s_d.rx.data = l_q.rx_word;
      // Reload reply just after a byte boundary, well before the next one
      s_d.tx_hold = tx_byte;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.sr <= `SR_RST;
      s_q.role_sel <= `ROLE_SEL_RST;
      s_q.fn <= `FN_RST;
      s_q.wp_m <= 1'b1;
      s_q.wp_s <= 1'b1;
      s_q.dl3_m <= 1'b1;
      s_q.dl3_s <= 1'b1;
      s_q.rpin_m <= 1'b1;
      s_q.rpin_s <= 1'b1;
      s_q.cs_m <= 1'b1;
      s_q.cs_s <= 1'b1;
      s_q.link_rst <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Link domain next state
  // ----------------------------------------
  always_comb
  begin
    l_d = l_q;
    l_d.rst_m = s_q.link_rst;
    l_d.rst_s = l_q.rst_m;
    l_d.pause_m = s_q.pause_role;
    l_d.pause_s = l_q.pause_m;
    l_d.quad_m = s_q.sr.quad_enable_bit;
    l_d.quad_s = l_q.quad_m;
    l_d.rep_m = reply_en;
    l_d.rep_s = l_q.rep_m;
    if (l_q.rst_s)
    begin
      l_d.cnt = '0;
      l_d.sh = '0;
      l_d.drv = 1'b0;
      l_d.so = 1'b0;
      l_d.tx = '0;
      l_d.rxt = 1'b0;
    end
    else if (cs_n)
    begin
      l_d.cnt = '0;
      l_d.drv = 1'b0;
    end
    else if (!(l_q.pause_s && !data_line_three_i))
    begin
      // Pause pin moves in step with sck; a paused edge leaves every bit untouched
      if (l_q.quad_s)
      begin
        l_d.sh = {l_q.sh[`BYTE_W-5:0], data_line_three_i, data_line_two_i, 1'b0, si};
        l_d.cnt = l_q.cnt + `CNT_STEP_QUAD;
      end
      else
      begin
        l_d.sh = {l_q.sh[`BYTE_W-2:0], si};
        l_d.cnt = l_q.cnt + `CNT_STEP_SINGLE;
      end
      l_d.tx = {l_q.tx[`BYTE_W-2:0], 1'b0};
      l_d.so = l_q.tx[`BYTE_W-1];
      l_d.drv = l_q.rep_s;
      if ((l_q.quad_s && l_q.cnt == `CNT_LAST_QUAD) ||
          (!l_q.quad_s && l_q.cnt == `CNT_LAST_SINGLE))
      begin
        l_d.cnt = '0;
        l_d.rx_word = l_d.sh;
        l_d.rxt = !l_q.rxt;
        l_d.tx = s_q.tx_hold;
      end
    end
  end

  always_ff @(posedge sck)
  begin
    l_q <= l_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign so_o = l_q.so;
  assign so_oe = s_q.so_oe;
  // Quad output path lives elsewhere; these pins only listen here
  assign data_line_two_o = s_q.refused && 1'b0;
  assign data_line_two_oe = s_q.refused && 1'b0;
  assign data_line_three_o = s_q.refused && 1'b0;
  assign data_line_three_oe = s_q.refused && 1'b0;
  assign status_q = s_q.sr;
  assign pin_role_select_bit = s_q.role_sel;
  assign func_cfg_q = s_q.fn;
  assign role_q = s_q.role;
  assign status_wr_refused = s_q.refused;
  assign pause_active = s_q.pause;
  assign device_in_reset = s_q.dev_rst;
  assign rx_q = s_q.rx;

endmodule : flash_pin_role_and_protect_logic

// [tb/flash_pin_checker.sv]
// Checker for pin roles, status write guard and output floating.
// Assumes a bind to the design module; all checks on sys_clk.
`timescale 1ns/1ns
`include "flash_pin_regs.svh"

module flash_pin_checker
  #(
    parameter bit HAS_DEDICATED_RESET = 1'b1
  )
  (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Inputs
    input wire logic cs_n,
    input wire logic status_wr,
    input wire flash_pin_pkg::status_t status_wdata,
    // Outputs
    input wire logic so_oe,
    input wire flash_pin_pkg::status_t status_q,
    input wire logic status_wr_refused,
    input wire logic pin_role_select_bit,
    input wire logic [`FN_W-1:0] func_cfg_q,
    input wire flash_pin_pkg::role_t role_q,
    input wire logic pause_active,
    input wire logic device_in_reset
  );
  import flash_pin_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  refused_keeps_a: assert property (status_wr_refused |-> $stable(status_q))
    else $error("refused write changed status");
  open_write_a: assert property (status_wr && !status_q.status_lock_bit |=>
    !status_wr_refused && status_q == $past(status_wdata))
    else $error("open status write lost");
  quad_no_wp_a: assert property (status_q.quad_enable_bit |=>
    !role_q.write_protect_live)
    else $error("write protect live in quad mode");
  quad_data_a: assert property (status_q.quad_enable_bit |=>
    role_q.shared_role == ROLE_DATA)
    else $error("shared pin not data in quad mode");
  select_role_a: assert property (!status_q.quad_enable_bit &&
    (func_cfg_q[`FN_RST_DIS_POS] || !HAS_DEDICATED_RESET) |=>
    role_q.shared_role == ($past(pin_role_select_bit) ? ROLE_RESET : ROLE_PAUSE))
    else $error("shared pin role ignores select bit");
  ded_pause_a: assert property (HAS_DEDICATED_RESET && !status_q.quad_enable_bit &&
    !func_cfg_q[`FN_RST_DIS_POS] |=> role_q.shared_role == ROLE_PAUSE)
    else $error("shared pin not pause with dedicated reset");
  ded_off_a: assert property (func_cfg_q[`FN_RST_DIS_POS] |=>
    !role_q.dedicated_reset_live)
    else $error("dedicated reset still live");
  pause_float_a: assert property (pause_active [*4] |-> !so_oe)
    else $error("output driven while paused");
  reset_float_a: assert property (device_in_reset [*4] |-> !so_oe)
    else $error("output driven in reset");
  deselect_float_a: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
endmodule : flash_pin_checker

// [tb/spi_host.sv]
// Host model: frames bytes MSB first and drives the pause pin.
// Assumes a 15 ns link clock, low between frames apart from three wake edges.
`timescale 1ns/1ns

module spi_host
  (
    // Link pins
    output logic sck,
    output logic cs_n,
    output logic si,
    // Pause or reset pin
    output logic pause_n,
    // Reply from the device
    input wire logic so
  );
  logic [7:0] rsp;

  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    pause_n = 1'b1;
    rsp = 8'h00;
  end

  // Deselected edges realign the link
  task wake();
    repeat (3)
    begin
      si = ~si;
      #7 sck = 1'b1;
      #8 sck = 1'b0;
    end
  endtask : wake

  task pin(input logic v);
    pause_n = v;
  endtask : pin

  // Pause low for edges pz..pz+9; a paused edge moves no bit either way
  task xfer(input logic [7:0] b, input int pz);
    int i;
    int e;
    i = 0;
    e = 0;
    cs_n = 1'b0;
    while (i < 8)
    begin
      pause_n = !(e >= pz && e < pz + 10);
      si = b[7-i];
      #7 sck = 1'b1;
      #8 sck = 1'b0;
      if (pause_n)
      begin
        i++;
        rsp = {rsp[6:0], so};
      end
      e++;
    end
    pause_n = 1'b1;
    cs_n = 1'b1;
    wake();
  endtask : xfer
endmodule : spi_host

// [tb/tb_top.sv]
// Self-checking bench for the flash pin role and protect block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ns
`include "flash_pin_regs.svh"

module tb_top;
  import flash_pin_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic sck;
  logic cs_n;
  logic si;
  logic so_o;
  logic data_line_two_i = 1'b1;
  logic data_line_three_i;
  logic reset_pin_n = 1'b1;
  logic status_wr = 1'b0;
  status_t status_wdata = 6'h00;
  logic role_wr = 1'b0;
  logic role_wdata = 1'b0;
  logic func_wr = 1'b0;
  logic [`FN_W-1:0] func_wdata = 8'h00;
  logic reply_en = 1'b1;
  logic [7:0] tx_byte = 8'hc3;
  logic so_oe;
  status_t status_q;
  logic pin_role_select_bit;
  logic [`FN_W-1:0] func_cfg_q;
  role_t role_q;
  logic status_wr_refused;
  logic pause_active;
  logic device_in_reset;
  byte_t rx_q;
  logic [7:0] last_rx = 8'h00;
  logic [3:0] n_rx = 4'h0;
  int err_count = 0;
  int num_checks = 0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (rx_q.valid === 1'b1)
    begin
      last_rx <= rx_q.data;
      n_rx <= n_rx + 4'h1;
    end

  spi_host u_spi_host (.sck, .cs_n, .si, .pause_n(data_line_three_i), .so(so_o));
  flash_pin_role_and_protect_logic u_flash_pin_role_and_protect_logic (.sys_clk, .srst, .sck,
    .cs_n, .si, .so_o, .so_oe, .data_line_two_i, .data_line_two_o(), .data_line_two_oe(),
    .data_line_three_i, .data_line_three_o(), .data_line_three_oe(), .reset_pin_n, .status_wr,
    .status_wdata, .role_wr, .role_wdata, .func_wr, .func_wdata, .reply_en, .tx_byte,
    .status_q, .pin_role_select_bit, .func_cfg_q, .role_q, .status_wr_refused, .pause_active,
    .device_in_reset, .rx_q);

  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task test_done();
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Waits for reset and pause flags, bounded
  task wait_for(input logic [1:0] exp);
    int k;
    k = 0;
    while ({device_in_reset, pause_active} !== exp && k < 20)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk({device_in_reset, pause_active}, exp);
    if ({device_in_reset, pause_active} !== exp)
      test_done();
  endtask : wait_for

  task st(input logic wp, input status_t v, input logic [6:0] e);
    @(posedge sys_clk);
    data_line_two_i <= wp;
    repeat (4) @(posedge sys_clk);
    status_wr <= 1'b1;
    status_wdata <= v;
    @(posedge sys_clk);
    status_wr <= 1'b0;
    #1;
    chk({status_wr_refused, status_q}, e);
  endtask : st

  task cfg(input logic f, input logic r);
    @(posedge sys_clk);
    func_wr <= 1'b1;
    func_wdata <= {7'h00, f};
    role_wr <= 1'b1;
    role_wdata <= r;
    @(posedge sys_clk);
    func_wr <= 1'b0;
    role_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : cfg

  task t_link();
    u_spi_host.wake();
    u_spi_host.xfer(8'ha5, 99);
    repeat (8) @(posedge sys_clk);
    chk({n_rx, last_rx}, 12'h1a5);
    u_spi_host.xfer(8'h3c, 3);
    repeat (8) @(posedge sys_clk);
    chk({n_rx, last_rx}, 12'h23c);
    u_spi_host.xfer(8'h5a, 2);
    repeat (8) @(posedge sys_clk);
    chk({n_rx, last_rx}, 12'h35a);
    chk(u_spi_host.rsp, 8'hc3);
  endtask : t_link

  task t_guard();
    st(1'b1, 6'h20, 7'h20);
    st(1'b0, 6'h2f, 7'h60);
    st(1'b1, 6'h0a, 7'h0a);
    st(1'b0, 6'h05, 7'h05);
    st(1'b0, 6'h30, 7'h30);
    st(1'b0, 6'h13, 7'h13);
    @(posedge sys_clk);
    #1;
    chk({role_q.shared_role, role_q.write_protect_live}, {ROLE_DATA, 1'b0});
    st(1'b1, 6'h00, 7'h00);
  endtask : t_guard

  task t_roles();
    for (int f = 0; f < 2; f++)
      for (int r = 0; r < 2; r++)
      begin
        cfg(f[0], r[0]);
        chk(role_q.shared_role, (f && r) ? ROLE_RESET : ROLE_PAUSE);
        chk(role_q.dedicated_reset_live, !f);
        u_spi_host.pin(1'b0);
        wait_for((f && r) ? 2'h2 : 2'h1);
        u_spi_host.pin(1'b1);
        wait_for(2'h0);
      end
    cfg(1'b0, 1'b0);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    wait_for(2'h2);
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    wait_for(2'h0);
  endtask : t_roles

  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_link();
    t_guard();
    t_roles();
    test_done();
  end
endmodule : tb_top

bind flash_pin_role_and_protect_logic flash_pin_checker #(
  .HAS_DEDICATED_RESET(HAS_DEDICATED_RESET)) u_flash_pin_checker (.sys_clk, .srst, .cs_n,
  .status_wr, .status_wdata, .so_oe, .status_q, .status_wr_refused, .pin_role_select_bit,
  .func_cfg_q, .role_q, .pause_active, .device_in_reset);
